// ### oop_pkg.sv
package oop_pkg;
    // ------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------
    localparam logic [15:0] OOP_ADDR_DATA = 16'hf210;
    localparam logic [15:0] OOP_ADDR_DRV_LO = 16'hf212;
    localparam logic [15:0] OOP_ADDR_DRV_HI = 16'hf213;
    localparam logic [15:0] OOP_ADDR_FUN_LO = 16'hf214;
    localparam logic [15:0] OOP_ADDR_FUN_HI = 16'hf215;
    localparam int OOP_PINS = 4;
    localparam int OOP_DATA_MSB = 3;
    localparam logic [7:0] OOP_REG_RESET = 8'h00;
    localparam logic [7:0] OOP_UNMAPPED_READ = 8'h00;
    localparam int OOP_PIN_TMB = 3;
    localparam int OOP_PIN_TM9 = 2;
    localparam int OOP_PIN_HSC = 1;
    localparam int OOP_PIN_LSC = 0;

    // Output driver codes, high bit from the high drive-select register.
    typedef enum logic [1:0] {
        OOP_DRV_HIZ = 2'b00,
        OOP_DRV_PCH = 2'b01,
        OOP_DRV_NCH = 2'b10,
        OOP_DRV_CMOS = 2'b11
    } oop_drive_t;

    // Function codes, high bit from the high function-select register.
    localparam logic [1:0] OOP_FUN_GPIO = 2'b00;
    localparam logic [1:0] OOP_FUN_ALT_A = 2'b01;
    localparam logic [1:0] OOP_FUN_ALT_B = 2'b10;
endpackage

// ### oop_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none
// Per-pin configuration carried from the register file to the pin drivers.
interface oop_cfg_if;
    logic [3:0] data;
    logic [3:0] drv_lo;
    logic [3:0] drv_hi;
    logic [3:0] fun_lo;
    logic [3:0] fun_hi;
    modport regs (output data, drv_lo, drv_hi, fun_lo, fun_hi);
    modport pins (input data, drv_lo, drv_hi, fun_lo, fun_hi);
endinterface
`default_nettype wire

// ### oop_pin_drv.sv
`timescale 1ns/1ns
`default_nettype none
module oop_pin_drv (
    input wire logic [oop_pkg::OOP_PINS-1:0] src,
    input wire logic [oop_pkg::OOP_PINS-1:0] code_hi,
    input wire logic [oop_pkg::OOP_PINS-1:0] code_lo,
    output logic [oop_pkg::OOP_PINS-1:0] pin_out,
    output logic [oop_pkg::OOP_PINS-1:0] pin_oe_n
);
    import oop_pkg::*;

    // ------------------------------------------------------------
    // Driver type per pin
    // ------------------------------------------------------------
    // Open-drain modes drive only one level; the other level floats.
    always_comb begin
        for (int i = 0; i < OOP_PINS; i++) begin
            pin_out[i] = src[i];
            unique case (oop_drive_t'({code_hi[i], code_lo[i]}))
                OOP_DRV_HIZ: pin_oe_n[i] = 1'b1;
                OOP_DRV_PCH: pin_oe_n[i] = ~src[i];
                OOP_DRV_NCH: pin_oe_n[i] = src[i];
                OOP_DRV_CMOS: pin_oe_n[i] = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### oop_port.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Data register bit n drives pin n.
// - Data register reads back written value.
// - Two drive bits select hiz, pch, nch, cmos.
// - Reset clears drive selects to high impedance.
// - Drive bits 3:0, byte or word access.
// - Pin three: 00 gpio, 10 timer b.
// - Pin two: 00 gpio, 10 timer nine.
// - Pin one: 00 gpio, 01 fast clock.
// - Pin zero: 00 gpio, 01 slow clock.
// - Output only; no direction, no input path.
// - Reset clears data and function selects.
module oop_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic wr_word,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic low_speed_clock_out,
    input wire logic high_speed_clock_out,
    input wire logic timer_nine_output,
    input wire logic timer_b_output,
    output logic [oop_pkg::OOP_PINS-1:0] pin_out,
    output logic [oop_pkg::OOP_PINS-1:0] pin_oe_n
);
    import oop_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] data;
        logic [3:0] drv_lo;
        logic [3:0] drv_hi;
        logic [3:0] fun_lo;
        logic [3:0] fun_hi;
        logic [15:0] rdata;
    } oop_state_t;

    oop_state_t st_ff;
    oop_state_t nxt_st;
    oop_cfg_if cfg ();
    logic [3:0] src;

    // Low nibble of a byte; upper bits are not stored and read as zero.
    function automatic logic [3:0] oop_nib(input logic [7:0] b);
        return b[OOP_DATA_MSB:0];
    endfunction

    function automatic logic [7:0] oop_byte(input logic [3:0] n);
        return {4'h0, n};
    endfunction

    // The two halves of a pin's function code live in separate
    // registers; joining them in one place keeps the bit order fixed.
    function automatic logic [1:0] oop_fun_code(input logic hi,
                                                input logic lo);
        return {hi, lo};
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // A word access at the drive-select low address also reaches the
    // high byte. All five registers read back their stored nibbles; pins are never read.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = 16'h0000;
        if (wr) begin
            unique case (addr)
                OOP_ADDR_DATA: nxt_st.data = oop_nib(wdata[7:0]);
                OOP_ADDR_DRV_LO: begin
                    nxt_st.drv_lo = oop_nib(wdata[7:0]);
                    if (wr_word) begin
                        nxt_st.drv_hi = oop_nib(wdata[15:8]);
                    end
                end
                OOP_ADDR_DRV_HI: nxt_st.drv_hi = oop_nib(wdata[7:0]);
                OOP_ADDR_FUN_LO: nxt_st.fun_lo = oop_nib(wdata[7:0]);
                OOP_ADDR_FUN_HI: nxt_st.fun_hi = oop_nib(wdata[7:0]);
                default: ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                OOP_ADDR_DATA:
                    nxt_st.rdata = {8'h00, oop_byte(st_ff.data)};
                OOP_ADDR_DRV_LO: nxt_st.rdata =
                    {oop_byte(st_ff.drv_hi), oop_byte(st_ff.drv_lo)};
                OOP_ADDR_DRV_HI: nxt_st.rdata = {8'h00, oop_byte(st_ff.drv_hi)};
                OOP_ADDR_FUN_LO: nxt_st.rdata = {8'h00, oop_byte(st_ff.fun_lo)};
                OOP_ADDR_FUN_HI: nxt_st.rdata = {8'h00, oop_byte(st_ff.fun_hi)};
                default: nxt_st.rdata = {8'h00, OOP_UNMAPPED_READ};
            endcase
        end
    end

    // Synchronous reset puts all pins in high impedance and gpio mode.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign cfg.data = st_ff.data;
    assign cfg.drv_lo = st_ff.drv_lo;
    assign cfg.drv_hi = st_ff.drv_hi;
    assign cfg.fun_lo = st_ff.fun_lo;
    assign cfg.fun_hi = st_ff.fun_hi;

    // ------------------------------------------------------------
    // Function multiplexer
    // ------------------------------------------------------------
    // Prohibited codes fall back to the data bit; software must avoid
    // them, so the fallback is only a safe default.
    always_comb begin
        src = cfg.data;
        if (oop_fun_code(cfg.fun_hi[OOP_PIN_TMB], cfg.fun_lo[OOP_PIN_TMB])
                == OOP_FUN_ALT_B) begin
            src[OOP_PIN_TMB] = timer_b_output;
        end
        if (oop_fun_code(cfg.fun_hi[OOP_PIN_TM9], cfg.fun_lo[OOP_PIN_TM9])
                == OOP_FUN_ALT_B) begin
            src[OOP_PIN_TM9] = timer_nine_output;
        end
        if (oop_fun_code(cfg.fun_hi[OOP_PIN_HSC], cfg.fun_lo[OOP_PIN_HSC])
                == OOP_FUN_ALT_A) begin
            src[OOP_PIN_HSC] = high_speed_clock_out;
        end
        if (oop_fun_code(cfg.fun_hi[OOP_PIN_LSC], cfg.fun_lo[OOP_PIN_LSC])
                == OOP_FUN_ALT_A) begin
            src[OOP_PIN_LSC] = low_speed_clock_out;
        end
    end

    // The drive code still governs a pin carrying a peripheral signal.
    oop_pin_drv u_drv (
        .src(src),
        .code_hi(cfg.drv_hi),
        .code_lo(cfg.drv_lo),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_data_write;
        wr && addr == OOP_ADDR_DATA;
    endsequence

    sequence s_data_read;
        rd && addr == OOP_ADDR_DATA && !wr;
    endsequence

    sequence s_word_write;
        wr && wr_word && addr == OOP_ADDR_DRV_LO;
    endsequence

    sequence s_word_read;
        rd && addr == OOP_ADDR_DRV_LO && !wr;
    endsequence

    chk_data_readback: assert property (
        s_data_write ##1 s_data_read |=> rdata[3:0] == $past(wdata[3:0], 2))
        else $error("Data register did not read back the written value.");

    chk_reset_clear: assert property (
        $rose(rst_n) |-> pin_oe_n == 4'hf && rdata == 16'h0000)
        else $error("Pins not in high impedance after reset.");

    chk_cmos_gpio: assert property (
        (cfg.drv_hi & cfg.drv_lo & ~cfg.fun_hi & ~cfg.fun_lo) == 4'hf
        |-> pin_oe_n == 4'h0 && pin_out == cfg.data)
        else $error("Gpio cmos pins do not follow the data register.");

    chk_nch_float: assert property (
        cfg.drv_hi[0] && !cfg.drv_lo[0] |-> pin_oe_n[0] == pin_out[0])
        else $error("N-channel pin 0 driven while high.");

    chk_word_write: assert property (
        wr && wr_word && addr == OOP_ADDR_DRV_LO
        |=> cfg.drv_hi == $past(wdata[11:8])
            && cfg.drv_lo == $past(wdata[3:0]))
        else $error("Word write missed a drive-select byte.");

    chk_timer_b: assert property (
        cfg.fun_hi[3] && !cfg.fun_lo[3] |-> pin_out[3] == timer_b_output)
        else $error("Pin 3 does not carry the timer b output.");

    chk_timer_nine: assert property (
        cfg.fun_hi[2] && !cfg.fun_lo[2] |-> pin_out[2] == timer_nine_output)
        else $error("Pin 2 does not carry the timer nine output.");

    chk_fast_clock: assert property (
        !cfg.fun_hi[1] && cfg.fun_lo[1] |-> pin_out[1] == high_speed_clock_out)
        else $error("Pin 1 does not carry the fast clock.");

    chk_slow_clock: assert property (
        !cfg.fun_hi[0] && cfg.fun_lo[0] |-> pin_out[0] == low_speed_clock_out)
        else $error("Pin 0 does not carry the slow clock.");

    // ------------------------------------------------------------
    // Register bus checks
    // ------------------------------------------------------------
    // Read data must drop back to zero, or software polling a status
    // would see a stale byte from an earlier read.
    chk_rdata_idle: assert property (
        !rd |=> rdata == 16'h0000)
        else $error("Read data did not return to zero after a read.");

    // A word written and read back at once must keep both bytes.
    chk_word_readback: assert property (
        s_word_write ##1 s_word_read
        |=> rdata == {4'h0, $past(wdata[11:8], 2), 4'h0,
                      $past(wdata[3:0], 2)})
        else $error("Word read did not return the word just written.");

    chk_data_write: assert property (
        wr && addr == OOP_ADDR_DATA
        |=> cfg.data == $past(wdata[3:0]))
        else $error("Data register write was lost.");

    chk_drv_lo_write: assert property (
        wr && addr == OOP_ADDR_DRV_LO
        |=> cfg.drv_lo == $past(wdata[3:0]))
        else $error("Low drive-select write was lost.");

    chk_drv_hi_write: assert property (
        wr && addr == OOP_ADDR_DRV_HI
        |=> cfg.drv_hi == $past(wdata[3:0]))
        else $error("High drive-select write was lost.");

    chk_fun_lo_write: assert property (
        wr && addr == OOP_ADDR_FUN_LO
        |=> cfg.fun_lo == $past(wdata[3:0]))
        else $error("Low function-select write was lost.");

    chk_fun_hi_write: assert property (
        wr && addr == OOP_ADDR_FUN_HI
        |=> cfg.fun_hi == $past(wdata[3:0]))
        else $error("High function-select write was lost.");

    // Only the nibble is stored, so a byte read shows zero above it.
    chk_byte_upper: assert property (
        rd && addr != OOP_ADDR_DRV_LO |=> rdata[15:4] == 12'h000)
        else $error("Byte read returned bits that are not stored.");

    chk_reset_regs: assert property (
        $rose(rst_n)
        |-> cfg.data == 4'h0 && cfg.fun_lo == 4'h0 && cfg.fun_hi == 4'h0)
        else $error("Data or function selects not clear after reset.");

    // ------------------------------------------------------------
    // Pin driver checks
    // ------------------------------------------------------------
    // Every pin in each drive code at once, so a swapped code bit on
    // any single pin shows up.
    chk_hiz_float: assert property (
        (~cfg.drv_hi & ~cfg.drv_lo & ~pin_oe_n) == 4'h0)
        else $error("A high impedance pin is being driven.");

    chk_cmos_drive: assert property (
        (cfg.drv_hi & cfg.drv_lo & pin_oe_n) == 4'h0)
        else $error("A cmos pin is floating.");

    chk_pch_level: assert property (
        (~cfg.drv_hi & cfg.drv_lo & ~(pin_oe_n ^ pin_out)) == 4'h0)
        else $error("A p-channel pin drives low or floats while high.");

    chk_nch_level: assert property (
        (cfg.drv_hi & ~cfg.drv_lo & (pin_oe_n ^ pin_out)) == 4'h0)
        else $error("An n-channel pin drives high or floats while low.");

    // Prohibited codes keep the data bit, so a stray write cannot
    // connect an unexpected peripheral to a pin.
    chk_bad_code_hi: assert property (
        cfg.fun_lo[3] |-> pin_out[3] == cfg.data[3])
        else $error("Pin 3 left the data bit on a prohibited code.");

    chk_bad_code_two: assert property (
        cfg.fun_lo[2] |-> pin_out[2] == cfg.data[2])
        else $error("Pin 2 left the data bit on a prohibited code.");

    chk_bad_code_one: assert property (
        cfg.fun_hi[1] |-> pin_out[1] == cfg.data[1])
        else $error("Pin 1 left the data bit on a prohibited code.");

    chk_bad_code_zero: assert property (
        cfg.fun_hi[0] |-> pin_out[0] == cfg.data[0])
        else $error("Pin 0 left the data bit on a prohibited code.");
endmodule
`default_nettype wire

// ### oop_led_load.sv
`timescale 1ns/1ns
`default_nettype none
module oop_led_load (
    input wire logic [oop_pkg::OOP_PINS-1:0] pin_out,
    input wire logic [oop_pkg::OOP_PINS-1:0] pin_oe_n,
    output logic [oop_pkg::OOP_PINS-1:0] pad
);
    import oop_pkg::*;
    // ------------------------------------------------------------
    // LED to the supply rail on every pin
    // ------------------------------------------------------------
    // A released pin is pulled up through its LED, so it never holds
    // the last driven level.
    always_comb begin
        for (int i = 0; i < OOP_PINS; i++) begin
            pad[i] = pin_oe_n[i] ? 1'b1 : pin_out[i];
        end
    end
endmodule
`default_nettype wire

// ### oop_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module oop_port_bench;
    import oop_pkg::*;
    logic clk, rst_n, wr, wr_word, rd;
    logic [15:0] addr, wdata, rdata;
    logic [3:0] per, pin_out, pin_oe_n, pad, sd, dl, dh, fl, fh;
    logic [15:0] dw [3];
    int failures, check_count, cyc;

    oop_port oop_port_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .wr_word(wr_word), .rd(rd), .rdata(rdata),
        .low_speed_clock_out(per[0]), .high_speed_clock_out(per[1]),
        .timer_nine_output(per[2]), .timer_b_output(per[3]),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    oop_led_load oop_led_load_inst (.pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pad(pad));

    // ------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------
    // The 40 ns clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // The run needs well under a thousand cycles; a hang is cut short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Compares and bus tasks
    // ------------------------------------------------------------
    task automatic cmp16(input string nm, input logic [15:0] e,
                         input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic cmp4(input string nm, input logic [3:0] e,
                        input logic [3:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask

    // One write cycle; the shadow copy keeps only the stored nibble.
    task automatic put(input logic [15:0] a, input logic [15:0] d,
                       input logic w);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_word <= w;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == OOP_ADDR_DATA) sd = d[3:0];
        if (a == OOP_ADDR_DRV_LO) dl = d[3:0];
        if (a == OOP_ADDR_DRV_LO && w) dh = d[11:8];
        if (a == OOP_ADDR_DRV_HI) dh = d[3:0];
        if (a == OOP_ADDR_FUN_LO) fl = d[3:0];
        if (a == OOP_ADDR_FUN_HI) fh = d[3:0];
        #1;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic get(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp16("rdata", e, rdata);
    endtask

    // Write then read with no idle cycle; read data stand one cycle only.
    task automatic b2b(input logic [15:0] a, input logic [15:0] d,
                       input logic w, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_word <= w;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp16("rdata b2b", e, rdata);
        @(posedge clk);
        #1 cmp16("rdata idle", 16'h0000, rdata);
    endtask

    // Pin source is the data bit unless the legal secondary code is set.
    task automatic chkpins();
        logic [3:0] eo, ep;
        logic s;
        for (int i = 0; i < 4; i++) begin
            s = sd[i];
            if ({fh[i], fl[i]} == ((i > 1) ? OOP_FUN_ALT_B : OOP_FUN_ALT_A))
                s = per[i];
            case ({dh[i], dl[i]})
                2'b00: eo[i] = 1'b1;
                2'b01: eo[i] = ~s;
                2'b10: eo[i] = s;
                default: eo[i] = 1'b0;
            endcase
            ep[i] = eo[i] | s;
        end
        cmp4("pin_oe_n", eo, pin_oe_n);
        cmp4("pad", ep, pad);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        {sd, dl, dh, fl, fh} = '0;
        #1 chkpins();
    endtask

    task automatic allzero();
        logic [15:0] ad [5];
        ad = '{OOP_ADDR_DATA, OOP_ADDR_DRV_LO, OOP_ADDR_DRV_HI,
               OOP_ADDR_FUN_LO, OOP_ADDR_FUN_HI};
        for (int i = 0; i < 5; i++) get(ad[i], {8'h00, OOP_REG_RESET});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, wr, wr_word, rd, per, addr, wdata} = '0;
        {failures, check_count, cyc} = '0;
        dw = '{16'h0c0a, 16'h0f0f, 16'h0f00};
        do_reset();
        allzero();
        get(16'hf211, {8'h00, OOP_UNMAPPED_READ});
        $display("test reset_state done");
        put(OOP_ADDR_DRV_LO, 16'h0f0f, 1'b1);
        get(OOP_ADDR_DRV_LO, 16'h0f0f);
        get(OOP_ADDR_DRV_HI, 16'h000f);
        for (int v = 0; v < 16; v++) begin
            put(OOP_ADDR_DATA, 16'(v + 16'h00a0), 1'b0);
            chkpins();
            get(OOP_ADDR_DATA, 16'(v));
        end
        b2b(OOP_ADDR_DATA, 16'h0035, 1'b0, 16'h0005);
        sd = 4'h5;
        chkpins();
        b2b(OOP_ADDR_DRV_LO, 16'h0f0f, 1'b1, 16'h0f0f);
        $display("test data_pins done");
        for (int c = 0; c < 4; c++) begin
            put(OOP_ADDR_DRV_LO, {12'h000, {4{c[0]}}}, 1'b0);
            put(OOP_ADDR_DRV_HI, {12'h000, {4{c[1]}}}, 1'b0);
            for (int v = 0; v < 16; v += 5) begin
                put(OOP_ADDR_DATA, 16'(v), 1'b0);
                chkpins();
            end
        end
        $display("test drive_codes done");
        put(OOP_ADDR_FUN_HI, 16'h000c, 1'b0);
        put(OOP_ADDR_FUN_LO, 16'h0003, 1'b0);
        for (int k = 0; k < 3; k++) begin
            put(OOP_ADDR_DRV_LO, dw[k], 1'b1);
            for (int v = 0; v < 16; v++) begin
                per <= 4'(v);
                put(OOP_ADDR_DATA, 16'(~v), 1'b0);
                chkpins();
            end
        end
        put(OOP_ADDR_FUN_HI, 16'h0000, 1'b0);
        put(OOP_ADDR_FUN_LO, 16'h0000, 1'b0);
        per <= 4'h5;
        put(OOP_ADDR_DATA, 16'h000a, 1'b0);
        chkpins();
        $display("test functions done");
        do_reset();
        allzero();
        $display("test second_reset done");
        close_out();
    end
endmodule
`default_nettype wire
